// file: hdl/mbss_defs.vh
// constants for the memory bus strobe and select generator
// assumes inclusion by the strobe generator only
`ifndef MBSS_DEFS_VH
`define MBSS_DEFS_VH

// =====================================================
// width and control style encodings
`define MBSS_WIDTH_X8        1'b0
`define MBSS_WIDTH_X16       1'b1
`define MBSS_STYLE_4WIRE     1'b0
`define MBSS_STYLE_5WIRE     1'b1

// =====================================================
// sequencer states
`define MBSS_ST_IDLE         2'h0
`define MBSS_ST_ODD          2'h1
`define MBSS_ST_EVEN         2'h2

// =====================================================
// reset values
`define MBSS_ADDR_RST        18'h00000
`define MBSS_DATA_RST        16'h0000

`endif

// file: hdl/mbss_region_match.v
// address region comparator: inclusive base..limit window
// assumes base and limit are held steady by configuration logic
`timescale 1ns/100ps

module mbss_region_match #(
    parameter AW = 18
) (
    input  wire [AW-1:0] addr_in,    // byte address under test
    input  wire [AW-1:0] base_in,    // first address of region
    input  wire [AW-1:0] limit_in,   // last address of region
    input  wire          enable_in,  // region in use
    output wire          hit_out     // address lies inside region
);

    // =================================================
    // comparison
    // an empty window (limit below base) never hits
    assign hit_out = enable_in && (addr_in >= base_in) &&
                     (addr_in <= limit_in);

endmodule

// file: hdl/mbss_strobe_gen.v
// Summary of operation
// - low byte enable on x16 5-wire low byte
// - output enable on reads, never on writes
// - low write enable on x8, x16 5-wire
// - x16 4-wire: low write only low byte
// - ram select when address in ram region
// - nonvolatile select in nonvolatile region, unless ram region also hits
// - x16 4-wire: high write on high byte
// - x8: shared pin is address bit zero
// - x8 word: odd byte before even byte
//
// memory bus strobe, byte-lane and chip-select generator
// assumes synchronous inputs on mclk_in; all strobes are active high
// here, pad inversion sits outside this block
`timescale 1ns/100ps
`include "mbss_defs.vh"

module mbss_strobe_gen #(
    parameter AW = 18                          // byte address width
) (
    input  wire          mclk_in,              // memory clock
    input  wire          rst_in,               // async reset, high
    input  wire          mem_width_in,         // 0 x8, 1 x16
    input  wire          mem_style_in,         // 0 4-wire, 1 5-wire
    input  wire [AW-1:0] ram_base_in,          // ram region first addr
    input  wire [AW-1:0] ram_limit_in,         // ram region last addr
    input  wire          ram_en_in,            // ram region in use
    input  wire [AW-1:0] nv_base_in,           // nv region first addr
    input  wire [AW-1:0] nv_limit_in,          // nv region last addr
    input  wire          nv_en_in,             // nv region in use
    input  wire          req_valid_in,         // access request
    input  wire          req_write_in,         // 1 write, 0 read
    input  wire [AW-1:0] req_addr_in,          // byte address
    input  wire [1:0]    req_bytes_in,         // [0] low, [1] high byte
    input  wire [15:0]   req_wdata_in,         // write data
    input  wire [15:0]   mem_rdata_in,         // data from memory pins
    output wire          req_ready_out,        // request taken
    output reg           done_out,             // access finished pulse
    output reg  [15:0]   rdata_out,            // assembled read data
    output reg  [AW-1:0] mem_addr_out,         // address, bit 0 below
    output reg  [15:0]   mem_data_bus_out,     // write data to pins
    output reg           mem_data_bus_oe_out,  // drive data pins
    output reg           mem_output_enable_out,
    output reg           low_byte_write_enable_out,
    output reg           addr0_or_high_write_enable_out,
    output reg           low_byte_enable_out,
    output reg           ram_select_out,
    output reg           nonvolatile_select_out,
    output wire          cycle_active_out      // bus cycle under way
);

    // =================================================
    // state and captured request
    reg [1:0]    state_q;    // sequencer state
    reg [1:0]    state_d;
    reg          wr_q;       // captured direction
    reg [AW-1:0] addr_q;     // captured address
    reg [1:0]    bytes_q;    // captured lanes
    reg [15:0]   wdata_q;    // captured write data
    reg          x8_q;       // width latched per access
    reg          five_q;     // style latched per access
    reg [15:0]   rbuf_q;     // read assembly

    // =================================================
    // region matching
    wire ram_hit;            // current address in ram area
    wire nv_hit;             // current address in nv area
    wire [AW-1:0] cyc_addr;  // address of the cycle now issued

    // cycle address is the captured word with bit 0 per phase
    assign cyc_addr = {addr_q[AW-1:1],
                       (state_q == `MBSS_ST_ODD)};

    mbss_region_match #(.AW(AW)) u_ram_match (
        .addr_in   (cyc_addr),
        .base_in   (ram_base_in),
        .limit_in  (ram_limit_in),
        .enable_in (ram_en_in),
        .hit_out   (ram_hit)
    );

    mbss_region_match #(.AW(AW)) u_nv_match (
        .addr_in   (cyc_addr),
        .base_in   (nv_base_in),
        .limit_in  (nv_limit_in),
        .enable_in (nv_en_in),
        .hit_out   (nv_hit)
    );

    assign req_ready_out    = (state_q == `MBSS_ST_IDLE);
    assign cycle_active_out = (state_q != `MBSS_ST_IDLE);

    // =================================================
    // next state
    // x8 with high lane requested goes through the odd phase first
    always @* begin
        state_d = state_q;
        case (state_q)
            `MBSS_ST_IDLE: begin
                if (req_valid_in) begin
                    if (mem_width_in == `MBSS_WIDTH_X8 &&
                        req_bytes_in[1]) begin
                        state_d = `MBSS_ST_ODD;
                    end else begin
                        state_d = `MBSS_ST_EVEN;
                    end
                end
            end
            `MBSS_ST_ODD: begin
                // even phase only when the low lane is wanted too
                if (bytes_q[0]) begin
                    state_d = `MBSS_ST_EVEN;
                end else begin
                    state_d = `MBSS_ST_IDLE;
                end
            end
            `MBSS_ST_EVEN: begin
                state_d = `MBSS_ST_IDLE;
            end
            default: begin
                state_d = `MBSS_ST_IDLE;
            end
        endcase
    end

    // =================================================
    // sequencer and capture registers
    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= `MBSS_ST_IDLE;
            wr_q    <= 1'b0;
            addr_q  <= `MBSS_ADDR_RST;
            bytes_q <= 2'h0;
            wdata_q <= `MBSS_DATA_RST;
            x8_q    <= 1'b0;
            five_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            if (req_valid_in && state_q == `MBSS_ST_IDLE) begin
                wr_q    <= req_write_in;
                addr_q  <= req_addr_in;
                bytes_q <= req_bytes_in;
                wdata_q <= req_wdata_in;
                x8_q    <= (mem_width_in == `MBSS_WIDTH_X8);
                five_q  <= (mem_style_in == `MBSS_STYLE_5WIRE);
            end
        end
    end

    // =================================================
    // pin strobes, registered one cycle per bus phase
    // strobes come from flops so the pads see no decode glitches
    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            mem_addr_out                   <= `MBSS_ADDR_RST;
            mem_data_bus_out               <= `MBSS_DATA_RST;
            mem_data_bus_oe_out            <= 1'b0;
            mem_output_enable_out          <= 1'b0;
            low_byte_write_enable_out      <= 1'b0;
            addr0_or_high_write_enable_out <= 1'b0;
            low_byte_enable_out            <= 1'b0;
            ram_select_out                 <= 1'b0;
            nonvolatile_select_out         <= 1'b0;
        end else if (state_q == `MBSS_ST_IDLE) begin
            // bus parked between cycles
            mem_data_bus_oe_out            <= 1'b0;
            mem_output_enable_out          <= 1'b0;
            low_byte_write_enable_out      <= 1'b0;
            addr0_or_high_write_enable_out <= 1'b0;
            low_byte_enable_out            <= 1'b0;
            ram_select_out                 <= 1'b0;
            nonvolatile_select_out         <= 1'b0;
        end else begin
            mem_addr_out        <= cyc_addr;
            mem_data_bus_oe_out <= wr_q;
            mem_output_enable_out <= !wr_q;
            ram_select_out      <= ram_hit;
            // ram wins if regions were misconfigured to overlap
            nonvolatile_select_out <= nv_hit && !ram_hit;
            if (x8_q) begin
                // x8: odd phase sends the high byte on low lane
                mem_data_bus_out <= (state_q == `MBSS_ST_ODD) ?
                    {8'h00, wdata_q[15:8]} : {8'h00, wdata_q[7:0]};
                low_byte_write_enable_out <= wr_q;
                addr0_or_high_write_enable_out <=
                    (state_q == `MBSS_ST_ODD);
                low_byte_enable_out <= 1'b0;
            end else if (five_q) begin
                // x16 5-wire: common write strobe, low byte enable
                mem_data_bus_out          <= wdata_q;
                low_byte_write_enable_out <= wr_q;
                addr0_or_high_write_enable_out <= 1'b0;
                low_byte_enable_out       <= bytes_q[0];
            end else begin
                // x16 4-wire: one write strobe per lane
                mem_data_bus_out          <= wdata_q;
                low_byte_write_enable_out <= wr_q && bytes_q[0];
                addr0_or_high_write_enable_out <=
                    wr_q && bytes_q[1];
                low_byte_enable_out       <= 1'b0;
            end
        end
    end

    // =================================================
    // read data assembly and completion
    // memory data is sampled the cycle after its strobe phase
    reg       sample_q;   // previous phase was a read
    reg       odd_q;      // previous phase was the odd one
    reg       last_q;     // previous phase ended the access
    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            sample_q  <= 1'b0;
            odd_q     <= 1'b0;
            last_q    <= 1'b0;
            rbuf_q    <= `MBSS_DATA_RST;
            rdata_out <= `MBSS_DATA_RST;
            done_out  <= 1'b0;
        end else begin
            sample_q <= cycle_active_out && !wr_q;
            odd_q    <= (state_q == `MBSS_ST_ODD);
            last_q   <= cycle_active_out &&
                        (state_d == `MBSS_ST_IDLE);
            done_out <= last_q;
            if (sample_q) begin
                if (!x8_q) begin
                    rbuf_q <= mem_rdata_in;
                end else if (odd_q) begin
                    rbuf_q <= {mem_rdata_in[7:0], rbuf_q[7:0]};
                end else begin
                    rbuf_q <= {rbuf_q[15:8], mem_rdata_in[7:0]};
                end
            end
            if (last_q) begin
                rdata_out <= !sample_q ? rbuf_q :
                    (!x8_q ? mem_rdata_in :
                     (odd_q ? {mem_rdata_in[7:0], rbuf_q[7:0]}
                            : {rbuf_q[15:8], mem_rdata_in[7:0]}));
            end
        end
    end

endmodule

// file: verif/mbss_mem_model.sv
// memory model for the strobe generator's pin side
// assumes a low-lane x8 or full x16 part answering on read strobe
`timescale 1ns/100ps
module mbss_mem_model (
    input  wire        oe_in,     // read strobe
    input  wire [17:0] addr_in,   // bus address
    output wire [15:0] rdata_out  // data to pins
);
    // ====================
    // address-coded data
    wire [15:0] data_w = {~addr_in[7:0], addr_in[7:0]};
    // released bus settles to the data pin pulls, never a stale word
    assign rdata_out = oe_in ? data_w : 16'hce00;
endmodule

// file: verif/mbss_strobe_gen_monitor.sv
// checker for the strobe generator, bound to its ports
// assumes width, style and regions change only while idle
`timescale 1ns/100ps
module mbss_strobe_gen_monitor (
    input wire        mclk_in,
    input wire        rst_in,
    input wire        mem_width_in,
    input wire        mem_style_in,
    input wire [17:0] ram_base_in,
    input wire [17:0] ram_limit_in,
    input wire        ram_en_in,
    input wire [17:0] nv_base_in,
    input wire [17:0] nv_limit_in,
    input wire        nv_en_in,
    input wire [17:0] mem_addr_out,
    input wire        mem_data_bus_oe_out,
    input wire        mem_output_enable_out,
    input wire        low_byte_write_enable_out,
    input wire        addr0_or_high_write_enable_out,
    input wire        low_byte_enable_out,
    input wire        ram_select_out,
    input wire        nonvolatile_select_out
);
    // ====================
    // properties
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    wire oe = mem_output_enable_out;
    wire lwe = low_byte_write_enable_out;
    wire a0h = addr0_or_high_write_enable_out;
    // one x8 bus phase, read or write
    sequence s_more; !mem_width_in && (oe || lwe); endsequence
    property p_rd; oe |-> !lwe && !mem_data_bus_oe_out; endproperty
    property p_sel; !(ram_select_out && nonvolatile_select_out); endproperty
    property p_ram; ram_select_out |-> ram_en_in &&
        mem_addr_out >= ram_base_in && mem_addr_out <= ram_limit_in;
    endproperty
    property p_nv; nonvolatile_select_out |-> nv_en_in &&
        mem_addr_out >= nv_base_in && mem_addr_out <= nv_limit_in;
    endproperty
    property p_lbe; low_byte_enable_out |-> mem_width_in && mem_style_in;
    endproperty
    property p_hwe; mem_width_in && a0h |->
        !mem_style_in && mem_data_bus_oe_out && !oe; endproperty
    property p_a0; !mem_width_in && (oe || lwe) |-> a0h == mem_addr_out[0];
    endproperty
    // two phases back to back: odd byte first, even byte second
    property p_odd; s_more ##1 s_more |-> !mem_addr_out[0] &&
        $past(mem_addr_out[0]); endproperty
    a_rd: assert property (p_rd) else $error("read with write");
    a_sel: assert property (p_sel) else $error("two selects");
    a_ram: assert property (p_ram) else $error("ram select");
    a_nv: assert property (p_nv) else $error("nv select");
    a_lbe: assert property (p_lbe) else $error("low enable");
    a_hwe: assert property (p_hwe) else $error("high write");
    a_a0: assert property (p_a0) else $error("address bit");
    a_odd: assert property (p_odd) else $error("byte order");
endmodule
bind mbss_strobe_gen mbss_strobe_gen_monitor u_mon (
    .mclk_in(mclk_in), .rst_in(rst_in), .mem_width_in(mem_width_in),
    .mem_style_in(mem_style_in), .ram_base_in(ram_base_in),
    .ram_limit_in(ram_limit_in), .ram_en_in(ram_en_in),
    .nv_base_in(nv_base_in), .nv_limit_in(nv_limit_in),
    .nv_en_in(nv_en_in), .mem_addr_out(mem_addr_out),
    .mem_data_bus_oe_out(mem_data_bus_oe_out),
    .mem_output_enable_out(mem_output_enable_out),
    .low_byte_write_enable_out(low_byte_write_enable_out),
    .addr0_or_high_write_enable_out(addr0_or_high_write_enable_out),
    .low_byte_enable_out(low_byte_enable_out),
    .ram_select_out(ram_select_out),
    .nonvolatile_select_out(nonvolatile_select_out));

// file: verif/test_memory_bus_strobe_select.sv
// bench for the strobe generator: every width, style, lane and region
// assumes the memory model answers reads; inputs move on falling edge
`timescale 1ns/100ps
module test_memory_bus_strobe_select;
    reg         mclk_in = 1'b0, rst_in = 1'b1;
    reg         mem_width_in = 1'b0, mem_style_in = 1'b0;
    reg         ram_en_in = 1'b0, nv_en_in = 1'b0;
    reg         req_valid_in = 1'b0, req_write_in = 1'b0;
    reg  [17:0] req_addr_in = 18'h00000;
    reg  [1:0]  req_bytes_in = 2'h0;
    reg  [15:0] req_wdata_in = 16'h0000;
    reg  [15:0] n_oe, n_lwe, n_hwe, n_lbe, n_rcs, n_ncs, np, m;
    reg  [15:0] n_ph, n_act;
    reg         f0, got, x8, dn, odd;
    wire [15:0] mem_rdata_in, rdata_out, md;
    wire [17:0] ma;
    wire        rdy, dn_w, oe, lwe, hwe, lbe, rcs, ncs, doe, act;
    integer     bad_count = 0, comparisons = 0, cyc = 0, j, k;
    always #4 mclk_in = ~mclk_in;
    mbss_strobe_gen u_dut (.mclk_in(mclk_in), .rst_in(rst_in),
        .mem_width_in(mem_width_in), .mem_style_in(mem_style_in),
        .ram_base_in(18'h00000), .ram_limit_in(18'h00fff),
        .ram_en_in(ram_en_in), .nv_base_in(18'h01000),
        .nv_limit_in(18'h01fff), .nv_en_in(nv_en_in),
        .req_valid_in(req_valid_in), .req_write_in(req_write_in),
        .req_addr_in(req_addr_in), .req_bytes_in(req_bytes_in),
        .req_wdata_in(req_wdata_in), .mem_rdata_in(mem_rdata_in),
        .req_ready_out(rdy), .done_out(dn_w), .rdata_out(rdata_out),
        .mem_addr_out(ma), .mem_data_bus_out(md), .mem_data_bus_oe_out(doe),
        .mem_output_enable_out(oe), .low_byte_write_enable_out(lwe),
        .addr0_or_high_write_enable_out(hwe), .low_byte_enable_out(lbe),
        .ram_select_out(rcs), .nonvolatile_select_out(ncs),
        .cycle_active_out(act));
    mbss_mem_model u_mem (.oe_in(oe), .addr_in(ma),
        .rdata_out(mem_rdata_in));
    // ====================
    // compare and verdict
    task check(input [17:0] seen, input [17:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
            end
        end
    endtask
    task results;
        begin
            if (bad_count == 0 && comparisons > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    // one access, counting each strobe's cycles until done
    task access(input w, input [17:0] a, input [1:0] b);
        begin
            while (rdy !== 1'b1) @(negedge mclk_in);
            req_valid_in = 1'b1;
            req_write_in = w;
            req_addr_in = a;
            req_bytes_in = b;
            req_wdata_in = {a[7:0], ~a[7:0]};
            @(negedge mclk_in);
            req_valid_in = 1'b0;
            {n_oe, n_lwe, n_hwe, n_lbe, n_rcs, n_ncs} = 96'h0;
            {n_ph, n_act} = 32'h0;
            got = 1'b0;
            dn = 1'b0;
            x8 = !mem_width_in;
            np = x8 ? b[0] + b[1] : 16'h0001;
            m = {{8{b[1]}}, {8{b[0]}}};
            for (k = 0; k < 16 && !dn; k = k + 1) begin
                n_oe = n_oe + oe;
                n_lwe = n_lwe + lwe;
                n_hwe = n_hwe + hwe;
                n_lbe = n_lbe + lbe;
                n_rcs = n_rcs + rcs;
                n_ncs = n_ncs + ncs;
                n_act = n_act + act;
                if ((oe || lwe) && !got) begin
                    f0 = ma[0];
                    got = 1'b1;
                end
                // each phase: full address, and write data on the pins
                if (oe || doe) begin
                    odd = x8 && b[1] && n_ph == 16'h0000;
                    check(ma, {a[17:1], odd});
                    if (doe) check(md, x8 ? {8'h00, odd ? a[7:0] : ~a[7:0]}
                        : {a[7:0], ~a[7:0]});
                    n_ph = n_ph + 1;
                end
                dn = (dn_w === 1'b1);
                if (!dn) @(negedge mclk_in);
            end
            check(dn, 1'b1);
            check(rdy, 1'b1);
            check(n_act, np);
            check(n_ph, np);
            check(n_oe, w ? 16'h0 : np);
            check(n_lwe, !w ? 16'h0 : (x8 || mem_style_in) ? np : b[0]);
            check(n_hwe, x8 ? b[1] : !mem_style_in && w && b[1]);
            check(n_lbe, !x8 && mem_style_in && b[0]);
            check(n_rcs, (ram_en_in && a < 18'h01000) ? np : 16'h0);
            check(n_ncs, (nv_en_in && a[17:12] == 6'h01) ? np : 16'h0);
            if (x8) check(f0, b[1]);
            if (!w) check(rdata_out & m, (x8 ? {a[7:0] | 8'h01, a[7:0]}
                : {~a[7:0], a[7:0]}) & m);
        end
    endtask
    // ====================
    // timeout and main sequence
    always @(posedge mclk_in) begin
        cyc = cyc + 1;
        if (cyc == 6000) begin
            bad_count = bad_count + 1;
            results;
        end
    end
    initial begin
        repeat (20) @(negedge mclk_in);
        rst_in = 1'b0;
        for (j = 0; j < 216; j = j + 1) begin
            {ram_en_in, nv_en_in} = j / 72 + 1;
            {mem_style_in, mem_width_in} = j % 4;
            access(j[2], 18'h00010 + (j / 24) % 3 * 18'h01010, (j / 8) % 3 + 1);
        end
        // mid-run reset right after a request is taken
        req_valid_in = 1'b1;
        @(negedge mclk_in);
        req_valid_in = 1'b0;
        rst_in = 1'b1;
        @(negedge mclk_in);
        check({oe, lwe, hwe, lbe, rcs, ncs, doe, act, dn_w}, 9'h000);
        check(ma, 18'h00000);
        check(md | rdata_out, 16'h0000);
        check(rdy, 1'b1);
        repeat (19) @(negedge mclk_in);
        rst_in = 1'b0;
        access(1'b0, 18'h01020, 2'h3);
        results;
    end
endmodule
